/* hw/vout_limit_input_turn_on_threshold_registers.sv */
// output-limit, margin, feedback ratio and turn-on register bank
// Overview of operation
// - a commanded output voltage above the upper limit is replaced by it.
// - a commanded output voltage below the lower limit is replaced by it.
// - any clamp sets the status-word vout bit, the max/min warning, alerts.
// - upper limit is 2 mV/LSB, resets 0x0226, capped at 5.5 V, 15:12 RO.
// - margin high is 2 mV/LSB, resets 0x0226, only bits 11:0 writable.
// - margin low is 2 mV/LSB and resets to 0x0190.
// - feedback ratio is 0.001/LSB and resets to 0x028C.
// - lower limit is 2 mV/LSB, resets 0x0170, never below 0.5 V.
// - conversion starts once input reaches turn-on and start is allowed.
// - turn-on is 250 mV/LSB in bits 5:0, resets 0x000C, 15:6 read-only.
// - conversion stops once the input falls to the turn-off level.
// - feedback reference is clamped command times the feedback ratio.
`timescale 1ns/1ps
module vout_limit_input_turn_on_threshold_registers (
  input  wire logic                          clk,
  input  wire logic                          reset_n,
  input  wire logic [7:0]                    cmd_code,
  input  wire logic                          wr_en,
  input  wire logic [15:0]                   wr_data,
  output      logic [15:0]                   rd_data,
  input  wire logic                          vout_load,
  input  wire logic [15:0]                   vout_command,
  input  wire logic [vout_limit_pkg::VIN_W-1:0] vin_level,
  input  wire logic [vout_limit_pkg::VIN_W-1:0] vin_off_level,
  input  wire logic                          start_ok,
  input  wire logic                          status_clear,
  output      logic [15:0]                   vout_target,
  output      logic [vout_limit_pkg::FB_W-1:0] fb_reference,
  output      logic                          status_word_vout,
  output      logic                          status_output_voltage_upper_limit_min,
  output      logic                          host_notify,
  output      logic                          conversion_on
);

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  logic [15:0] vout_upper,  next_vout_upper;
  logic [15:0] margin_high, next_margin_high;
  logic [15:0] margin_low,  next_margin_low;
  logic [15:0] fb_ratio,    next_fb_ratio;
  logic [15:0] vout_lower,  next_vout_lower;
  logic [15:0] input_turn_on_threshold,      next_input_turn_on_threshold;
  logic [15:0] next_rd_data;

  // host writes, masked and bounded; unmapped codes change nothing
  always_comb begin
    next_vout_upper  = vout_upper;
    next_margin_high = margin_high;
    next_margin_low  = margin_low;
    next_fb_ratio    = fb_ratio;
    next_vout_lower  = vout_lower;
    next_input_turn_on_threshold      = input_turn_on_threshold;
    if (wr_en) begin
      unique case (cmd_code)
        vout_limit_pkg::ADDR_VOUT_UPPER: begin
          next_vout_upper = vout_limit_pkg::bound(
            vout_limit_pkg::keep_bits(wr_data, vout_limit_pkg::MASK_VOLT),
            16'h0000, vout_limit_pkg::VOUT_UPPER_CEIL);
        end
        vout_limit_pkg::ADDR_MARGIN_HIGH: begin
          next_margin_high = vout_limit_pkg::keep_bits(wr_data,
            vout_limit_pkg::MASK_VOLT);
        end
        vout_limit_pkg::ADDR_MARGIN_LOW: begin
          next_margin_low = vout_limit_pkg::keep_bits(wr_data,
            vout_limit_pkg::MASK_VOLT);
        end
        vout_limit_pkg::ADDR_FB_RATIO: begin
          next_fb_ratio = vout_limit_pkg::keep_bits(wr_data,
            vout_limit_pkg::MASK_VOLT);
        end
        vout_limit_pkg::ADDR_VOUT_LOWER: begin
          next_vout_lower = vout_limit_pkg::bound(
            vout_limit_pkg::keep_bits(wr_data, vout_limit_pkg::MASK_VOLT),
            vout_limit_pkg::VOUT_LOWER_FLOOR,
            vout_limit_pkg::MASK_VOLT);
        end
        vout_limit_pkg::ADDR_INPUT_TURN_ON_THRESHOLD: begin
          next_input_turn_on_threshold = vout_limit_pkg::keep_bits(wr_data,
            vout_limit_pkg::MASK_VIN);
        end
        default: ;
      endcase
    end
  end

  // read mux, registered so the answer follows the code by one clock
  always_comb begin
    unique case (cmd_code)
      vout_limit_pkg::ADDR_VOUT_UPPER:  next_rd_data = vout_upper;
      vout_limit_pkg::ADDR_MARGIN_HIGH: next_rd_data = margin_high;
      vout_limit_pkg::ADDR_MARGIN_LOW:  next_rd_data = margin_low;
      vout_limit_pkg::ADDR_FB_RATIO:    next_rd_data = fb_ratio;
      vout_limit_pkg::ADDR_VOUT_LOWER:  next_rd_data = vout_lower;
      vout_limit_pkg::ADDR_INPUT_TURN_ON_THRESHOLD:      next_rd_data = input_turn_on_threshold;
      default: next_rd_data = vout_limit_pkg::READ_UNMAPPED;
    endcase
  end

  // register file flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vout_upper  <= vout_limit_pkg::RST_VOUT_UPPER;
      margin_high <= vout_limit_pkg::RST_MARGIN_HIGH;
      margin_low  <= vout_limit_pkg::RST_MARGIN_LOW;
      fb_ratio    <= vout_limit_pkg::RST_FB_RATIO;
      vout_lower  <= vout_limit_pkg::RST_VOUT_LOWER;
      input_turn_on_threshold      <= vout_limit_pkg::RST_INPUT_TURN_ON_THRESHOLD;
      rd_data     <= vout_limit_pkg::READ_UNMAPPED;
    end else begin
      vout_upper  <= next_vout_upper;
      margin_high <= next_margin_high;
      margin_low  <= next_margin_low;
      fb_ratio    <= next_fb_ratio;
      vout_lower  <= next_vout_lower;
      input_turn_on_threshold      <= next_input_turn_on_threshold;
      rd_data     <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------------
  // output voltage clamp and warning flags
  // ----------------------------------------------------------------------
  vout_clamp_if lim ();
  assign lim.command = vout_command;
  assign lim.upper   = vout_upper;
  assign lim.lower   = vout_lower;
  vout_clamp u_clamp (
    .lim (lim.unit)
  );

  logic [15:0]                     next_vout_target;
  logic                            next_word_vout;
  logic                            next_max_min;
  logic                            clamp_event;
  logic [vout_limit_pkg::FB_W-1:0] next_fb_reference;

  // a clamp in the same cycle as a clear wins, so no event is lost
  always_comb begin
    clamp_event      = vout_load && (lim.above || lim.below);
    next_vout_target = vout_load ? lim.target : vout_target;
    next_word_vout   = (status_word_vout && !status_clear)
                       || clamp_event;
    next_max_min     = (status_output_voltage_upper_limit_min && !status_clear)
                       || clamp_event;
    next_fb_reference = vout_limit_pkg::FB_W'(vout_target[11:0])
                        * vout_limit_pkg::FB_W'(fb_ratio[11:0]);
  end

  // limits are applied at load time only; a later limit write does not
  // re-clamp a target already in force
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      vout_target         <= 16'h0000;
      status_word_vout    <= 1'b0;
      status_output_voltage_upper_limit_min <= 1'b0;
      host_notify         <= 1'b0;
      fb_reference        <= '0;
    end else begin
      vout_target         <= next_vout_target;
      status_word_vout    <= next_word_vout;
      status_output_voltage_upper_limit_min <= next_max_min;
      host_notify         <= next_word_vout || next_max_min;
      fb_reference        <= next_fb_reference;
    end
  end

  // ----------------------------------------------------------------------
  // input turn-on / turn-off control
  // ----------------------------------------------------------------------
  vout_limit_pkg::conv_state_t conv_state, next_conv_state;

  // hysteresis relies on the host keeping turn-on above turn-off
  always_comb begin
    next_conv_state = conv_state;
    unique case (conv_state)
      vout_limit_pkg::CONV_OFF: begin
        if (start_ok && vin_level >= input_turn_on_threshold[vout_limit_pkg::VIN_W-1:0]) begin
          next_conv_state = vout_limit_pkg::CONV_ON;
        end
      end
      vout_limit_pkg::CONV_ON: begin
        if (vin_level <= vin_off_level) begin
          next_conv_state = vout_limit_pkg::CONV_OFF;
        end
      end
      default: next_conv_state = vout_limit_pkg::CONV_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      conv_state    <= vout_limit_pkg::CONV_OFF;
      conversion_on <= 1'b0;
    end else begin
      conv_state    <= next_conv_state;
      conversion_on <= next_conv_state == vout_limit_pkg::CONV_ON;
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  sequence s_load_high;
    vout_load && (vout_command > vout_upper);
  endsequence

  sequence s_load_low;
    vout_load && (vout_command <= vout_upper)
      && (vout_command < vout_lower);
  endsequence

  property p_clamp_high;
    @(posedge clk) disable iff (!reset_n)
    s_load_high |=> vout_target == $past(vout_upper);
  endproperty
  a_clamp_high: assert property (p_clamp_high)
    else $error("target not clamped to upper limit");

  property p_clamp_low;
    @(posedge clk) disable iff (!reset_n)
    s_load_low |=> vout_target == $past(vout_lower);
  endproperty
  a_clamp_low: assert property (p_clamp_low)
    else $error("target not clamped to lower limit");

  property p_clamp_flags;
    @(posedge clk) disable iff (!reset_n)
    (s_load_high or s_load_low) |=>
      status_word_vout && status_output_voltage_upper_limit_min && host_notify;
  endproperty
  a_clamp_flags: assert property (p_clamp_flags)
    else $error("clamp did not raise status and alert");

  property p_upper_bound;
    @(posedge clk) disable iff (!reset_n)
    wr_en && cmd_code == vout_limit_pkg::ADDR_VOUT_UPPER |=>
      vout_upper <= vout_limit_pkg::VOUT_UPPER_CEIL
      && vout_upper[15:12] == 4'h0;
  endproperty
  a_upper_bound: assert property (p_upper_bound)
    else $error("upper limit beyond ceiling or high bits set");

  property p_margin_high_wr;
    @(posedge clk) disable iff (!reset_n)
    wr_en && cmd_code == vout_limit_pkg::ADDR_MARGIN_HIGH |=>
      margin_high == ($past(wr_data) & vout_limit_pkg::MASK_VOLT);
  endproperty
  a_margin_high_wr: assert property (p_margin_high_wr)
    else $error("margin high write not stored as masked");

  property p_lower_bound;
    @(posedge clk) disable iff (!reset_n)
    wr_en && cmd_code == vout_limit_pkg::ADDR_VOUT_LOWER |=>
      vout_lower >= vout_limit_pkg::VOUT_LOWER_FLOOR;
  endproperty
  a_lower_bound: assert property (p_lower_bound)
    else $error("lower limit below floor");

  property p_turn_on;
    @(posedge clk) disable iff (!reset_n)
    conv_state == vout_limit_pkg::CONV_OFF && start_ok
      && vin_level >= input_turn_on_threshold[vout_limit_pkg::VIN_W-1:0]
      |=> conversion_on;
  endproperty
  a_turn_on: assert property (p_turn_on)
    else $error("conversion did not start at turn-on level");

  property p_turn_off;
    @(posedge clk) disable iff (!reset_n)
    conversion_on && vin_level <= vin_off_level |=> !conversion_on;
  endproperty
  a_turn_off: assert property (p_turn_off)
    else $error("conversion did not stop at turn-off level");

  property p_fb_ref;
    @(posedge clk) disable iff (!reset_n)
    vout_load ##1 !vout_load |=>
      fb_reference == vout_limit_pkg::FB_W'($past(vout_target[11:0]))
                      * vout_limit_pkg::FB_W'($past(fb_ratio[11:0]));
  endproperty
  a_fb_ref: assert property (p_fb_ref)
    else $error("feedback reference not command times ratio");

  property p_ro_zero;
    @(posedge clk) disable iff (!reset_n)
    1'b1 |=> input_turn_on_threshold[15:6] == 10'h000 && margin_low[15:12] == 4'h0
      && fb_ratio[15:12] == 4'h0;
  endproperty
  a_ro_zero: assert property (p_ro_zero)
    else $error("read-only bits not zero");

endmodule : vout_limit_input_turn_on_threshold_registers

/* hw/vout_limit_pkg.sv */
// constants, types and helpers shared by the output-limit register bank
package vout_limit_pkg;

  // ----------------------------------------------------------------------
  // command codes of the registers
  // ----------------------------------------------------------------------
  localparam logic [7:0]  ADDR_VOUT_UPPER   = 8'h24;
  localparam logic [7:0]  ADDR_MARGIN_HIGH  = 8'h25;
  localparam logic [7:0]  ADDR_MARGIN_LOW   = 8'h26;
  localparam logic [7:0]  ADDR_FB_RATIO     = 8'h29;
  localparam logic [7:0]  ADDR_VOUT_LOWER   = 8'h2B;
  localparam logic [7:0]  ADDR_INPUT_TURN_ON_THRESHOLD       = 8'h35;

  // ----------------------------------------------------------------------
  // reset values, writable masks and value bounds
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_VOUT_UPPER    = 16'h0226;
  localparam logic [15:0] RST_MARGIN_HIGH   = 16'h0226;
  localparam logic [15:0] RST_MARGIN_LOW    = 16'h0190;
  localparam logic [15:0] RST_FB_RATIO      = 16'h028C;
  localparam logic [15:0] RST_VOUT_LOWER    = 16'h0170;
  localparam logic [15:0] RST_INPUT_TURN_ON_THRESHOLD        = 16'h000C;
  localparam logic [15:0] MASK_VOLT         = 16'h0FFF;
  localparam logic [15:0] MASK_VIN          = 16'h003F;
  localparam logic [15:0] VOUT_UPPER_CEIL   = 16'h0ABE; // 5.5 V at 2 mV
  localparam logic [15:0] VOUT_LOWER_FLOOR  = 16'h00FA; // 0.5 V at 2 mV
  localparam logic [15:0] READ_UNMAPPED     = 16'h0000;
  localparam int          VIN_W             = 6;
  localparam int          FB_W              = 24;

  // ----------------------------------------------------------------------
  // converter enable states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CONV_OFF = 2'b01,
    CONV_ON  = 2'b10
  } conv_state_t;

  // keeps only writable bits, the rest read back as zero
  function automatic logic [15:0] keep_bits(input logic [15:0] data,
                                            input logic [15:0] mask);
    return data & mask;
  endfunction : keep_bits

  // folds a value into [lo, hi]
  function automatic logic [15:0] bound(input logic [15:0] v,
                                        input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v > hi) begin
      return hi;
    end else if (v < lo) begin
      return lo;
    end
    return v;
  endfunction : bound

endpackage : vout_limit_pkg

/* hw/vout_clamp_if.sv */
// carrier between the register bank and its clamp unit
`timescale 1ns/1ps
interface vout_clamp_if;
  logic [15:0] command;
  logic [15:0] upper;
  logic [15:0] lower;
  logic [15:0] target;
  logic        above;
  logic        below;

  modport client (output command, output upper, output lower,
                  input  target,  input  above, input  below);
  modport unit   (input  command, input  upper, input  lower,
                  output target,  output above, output below);
endinterface : vout_clamp_if

/* hw/vout_clamp.sv */
// combinational clamp of a commanded output voltage to its limits
`timescale 1ns/1ps
module vout_clamp (
  vout_clamp_if.unit lim
);

  // ----------------------------------------------------------------------
  // compare and substitute
  // ----------------------------------------------------------------------
  // upper limit checked first: with crossed limits a command above both gets the upper limit
  always_comb begin
    lim.above  = lim.command > lim.upper;
    lim.below  = !lim.above && (lim.command < lim.lower);
    lim.target = lim.command;
    if (lim.above) begin
      lim.target = lim.upper;
    end else if (lim.below) begin
      lim.target = lim.lower;
    end
  end

endmodule : vout_clamp

/* tb/host_model.sv */
// behavioural host that reaches the limit registers through their port
`timescale 1ns/1ps
module host_model (
  input  wire logic        clk,
  output      logic [7:0]  cmd_code,
  output      logic        wr_en,
  output      logic [15:0] wr_data,
  input  wire logic [15:0] rd_data
);
  // ----------------------------------------------------------------------
  // register access
  // ----------------------------------------------------------------------
  // idle bus at time zero
  initial begin
    cmd_code = 8'h00;
    wr_en    = 1'b0;
    wr_data  = 16'h0000;
  end

  // one word a write; data is inverted after release so stale data shows
  task automatic put_word(input logic [7:0] addr, input logic [15:0] data);
    @(posedge clk);
    cmd_code <= addr;
    wr_en    <= 1'b1;
    wr_data  <= data;
    @(posedge clk);
    wr_en    <= 1'b0;
    wr_data  <= ~data;
  endtask : put_word

  // read data settles one edge after the code; wait two to be safe
  task automatic get_word(input logic [7:0] addr, output logic [15:0] data);
    @(posedge clk);
    cmd_code <= addr;
    repeat (2) @(posedge clk);
    #1;
    data = rd_data;
  endtask : get_word
endmodule : host_model

/* tb/vout_limit_input_turn_on_threshold_registers_tb_top.sv */
// self-checking bench for the output-limit and turn-on register bank
`timescale 1ns/1ps
module vout_limit_input_turn_on_threshold_registers_tb_top;
  logic        clk;
  logic        reset_n;
  logic [7:0]  cmd_code;
  logic        wr_en;
  logic [15:0] wr_data;
  logic [15:0] rd_data;
  logic        vout_load;
  logic [15:0] vout_command;
  logic [5:0]  vin_level;
  logic [5:0]  vin_off_level;
  logic        start_ok;
  logic        status_clear;
  logic [15:0] vout_target;
  logic [23:0] fb_reference;
  logic        status_word_vout;
  logic        status_output_voltage_upper_limit_min;
  logic        host_notify;
  logic        conversion_on;
  int          fails;
  int          checked;

  vout_limit_input_turn_on_threshold_registers dut (
    .clk(clk), .reset_n(reset_n), .cmd_code(cmd_code), .wr_en(wr_en),
    .wr_data(wr_data), .rd_data(rd_data), .vout_load(vout_load),
    .vout_command(vout_command), .vin_level(vin_level),
    .vin_off_level(vin_off_level), .start_ok(start_ok),
    .status_clear(status_clear), .vout_target(vout_target),
    .fb_reference(fb_reference), .status_word_vout(status_word_vout),
    .status_output_voltage_upper_limit_min(status_output_voltage_upper_limit_min), .host_notify(host_notify),
    .conversion_on(conversion_on)
  );

  host_model u_host (
    .clk(clk), .cmd_code(cmd_code), .wr_en(wr_en), .wr_data(wr_data),
    .rd_data(rd_data)
  );

  // 40 MHz clock
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  // ----------------------------------------------------------------------
  // shared helpers
  // ----------------------------------------------------------------------
  task automatic chk(input string what, input logic [23:0] seen,
                     input logic [23:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    if (fails == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim

  // reset is held for 20 cycles each time
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  // every register reads its reset value, an unmapped code reads zero
  task automatic t_reset();
    logic [7:0]  ra [7];
    logic [15:0] rv [7];
    logic [15:0] d;
    ra = '{8'h24, 8'h25, 8'h26, 8'h29, 8'h2B, 8'h35, 8'h27};
    rv = '{16'h0226, 16'h0226, 16'h0190, 16'h028C, 16'h0170, 16'h000C,
           16'h0000};
    chk("target_at_reset", 24'(vout_target), 24'h000000);
    chk("conv_at_reset", 24'(conversion_on), 24'h000000);
    for (int i = 0; i < 7; i++) begin
      u_host.get_word(ra[i], d);
      chk("reset", 24'(d), 24'(rv[i]));
    end
  endtask : t_reset

  // read-only bits drop, limits saturate, unmapped writes vanish
  task automatic t_writes();
    logic [7:0]  wa [10];
    logic [15:0] wd [10];
    logic [15:0] we [10];
    logic [15:0] d;
    wa = '{8'h25, 8'h26, 8'h29, 8'h35, 8'h24, 8'h24, 8'h2B, 8'h24, 8'h2B,
           8'h27};
    wd = '{16'hFFFF, 16'hF123, 16'hA3E8, 16'hFFD0, 16'h0FFF, 16'h0ABE,
           16'h00F9, 16'h0400, 16'h0190, 16'hFFFF};
    we = '{16'h0FFF, 16'h0123, 16'h03E8, 16'h0010, 16'h0ABE, 16'h0ABE,
           16'h00FA, 16'h0400, 16'h0190, 16'h0000};
    // the ratio ends at 1.000 for a unity divider, turn-on at 4 V
    for (int i = 0; i < 10; i++) begin
      u_host.put_word(wa[i], wd[i]);
      u_host.get_word(wa[i], d);
      chk("write", 24'(d), 24'(we[i]));
    end
  endtask : t_writes

  // commanded voltages clamp to the limits and raise the warnings
  task automatic t_clamp();
    logic [15:0] lc [6];
    logic [15:0] lt [6];
    logic        lf [6];
    logic [23:0] fb;
    lc = '{16'h0500, 16'h0400, 16'h0300, 16'h0190, 16'h0100, 16'hFFFF};
    lt = '{16'h0400, 16'h0400, 16'h0300, 16'h0190, 16'h0190, 16'h0400};
    lf = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      status_clear <= 1'b1;
      @(posedge clk);
      status_clear <= 1'b0;
      vout_load    <= 1'b1;
      vout_command <= lc[i];
      @(posedge clk);
      vout_load    <= 1'b0;
      #1;
      chk("vout_target", 24'(vout_target), 24'(lt[i]));
      chk("status_word_vout", 24'(status_word_vout), 24'(lf[i]));
      chk("max_min_warn", 24'(status_output_voltage_upper_limit_min), 24'(lf[i]));
      chk("host_notify", 24'(host_notify), 24'(lf[i]));
      @(posedge clk);
      #1;
      fb = 24'(lt[i][11:0]) * 24'h0003E8;
      chk("fb_reference", fb_reference, fb);
    end
    // a clamp that meets a clear in the same cycle must still raise the flag
    @(posedge clk);
    status_clear <= 1'b1;
    vout_load    <= 1'b1;
    vout_command <= 16'h0100;
    @(posedge clk);
    status_clear <= 1'b0;
    vout_load    <= 1'b0;
    #1;
    chk("set_beats_clear", 24'(status_output_voltage_upper_limit_min), 24'h000001);
    chk("set_beats_clear_word", 24'(status_word_vout), 24'h000001);
    @(posedge clk);
    status_clear <= 1'b1;
    @(posedge clk);
    status_clear <= 1'b0;
    @(posedge clk);
    #1;
    chk("notify_cleared", 24'(host_notify), 24'h000000);
    chk("word_cleared", 24'(status_word_vout), 24'h000000);
    chk("max_min_cleared", 24'(status_output_voltage_upper_limit_min), 24'h000000);
  endtask : t_clamp

  // one input step, then the converter state one edge after sampling
  task automatic conv_step(input logic [5:0] v, input logic ok,
                           input logic exp);
    @(posedge clk);
    vin_level <= v;
    start_ok  <= ok;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("conversion_on", 24'(conversion_on), 24'(exp));
  endtask : conv_step

  // turn-on is 16 steps; turn-off sits below it with margin
  task automatic t_turn_on();
    @(posedge clk);
    vin_off_level <= 6'h0B;
    conv_step(6'h14, 1'b0, 1'b0);
    conv_step(6'h0F, 1'b1, 1'b0);
    conv_step(6'h10, 1'b1, 1'b1);
    conv_step(6'h0C, 1'b1, 1'b1);
    conv_step(6'h0B, 1'b1, 1'b0);
  endtask : t_turn_on

  // ----------------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------------
  initial begin
    fails         = 0;
    checked       = 0;
    reset_n       = 1'b0;
    vout_load     = 1'b0;
    vout_command  = 16'h0000;
    vin_level     = 6'h00;
    vin_off_level = 6'h00;
    start_ok      = 1'b0;
    status_clear  = 1'b0;
    do_reset();
    t_reset();
    t_writes();
    t_clamp();
    t_turn_on();
    // a second reset must bring every register back
    do_reset();
    @(posedge clk);
    #1;
    t_reset();
    end_sim();
  end

  // a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    end_sim();
  end
endmodule : vout_limit_input_turn_on_threshold_registers_tb_top
